// ===== hdl/ffi_irq_logic.sv
// Interrupt source, mask and clear logic for the flash memory controller FIFOs
// =====================================================
`timescale 1ns/1ps
`include "ffi_regs.svh"
module ffi_irq_logic
  import ffi_pkg::*;
#(
  parameter int LEVEL_W = 8
)(
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  // Register port
  input  wire logic               reg_sel,
  input  wire logic               reg_write,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  output logic      [31:0]        reg_rdata,
  // Transmit FIFO side
  input  wire logic               xmt_empty,
  input  wire logic               xmt_full,
  input  wire logic [LEVEL_W-1:0] xmt_space,
  input  wire logic               xmt_bus_write,
  input  wire ffi_width_t         xmt_bus_width,
  input  wire logic [1:0]         xmt_byte_ptr,
  input  wire logic               xmt_ext_pop,
  input  wire logic               xmt_ext_misalign,
  // Receive FIFO side
  input  wire logic               rcv_full,
  input  wire logic               rcv_empty,
  input  wire logic [LEVEL_W-1:0] rcv_count,
  input  wire logic               rcv_bus_read,
  input  wire logic               rcv_bus_misalign,
  input  wire logic               rcv_ext_push_fault,
  // Flash completion events, bits 14..10
  input  wire logic [4:0]         flash_events,
  output logic                    irq
);
  // =====================================================
  // Parameter check
  // Thresholds are 8 bits; counts beyond 16 bits would only waste compare logic
  if (LEVEL_W < 1 || LEVEL_W > 16)
  begin : g_bad_level_w
    $error("ffi_irq_logic: LEVEL_W out of range");
  end

  // =====================================================
  // Registers
  ffi_src_t    raw_q;                    // Raw source flags
  ffi_src_t    raw_d;
  logic [31:0] mask_q;                   // Bits 31..15 are storage only
  logic [31:0] mask_d;
  logic [15:0] thresh_q;                 // [7:0] receive level, [15:8] transmit space
  logic [15:0] thresh_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // =====================================================
  // Write decode
  // Accesses last one cycle, so a write acts exactly once
  wire acc_wr    = reg_sel & reg_write;
  wire wr_mask   = acc_wr & (reg_addr == `FFI_OFS_MASK);
  wire wr_clear  = acc_wr & (reg_addr == `FFI_OFS_CLEAR);
  wire wr_thresh = acc_wr & (reg_addr == `FFI_OFS_THRESH);
  wire rd_any    = reg_sel & ~reg_write;

  // =====================================================
  // Threshold compare
  // Both sides widened to 16 bits so a narrow count never cuts the threshold
  wire [7:0]  rcv_thresh = thresh_q[7:0];
  wire [7:0]  xmt_thresh = thresh_q[15:8];
  wire [15:0] rcv_wide   = 16'(rcv_count);
  wire [15:0] xmt_wide   = 16'(xmt_space);
  wire        rcv_over   = rcv_wide > {8'h00, rcv_thresh};
  wire        xmt_over   = xmt_wide > {8'h00, xmt_thresh};

  // =====================================================
  // Level edges
  // Flags follow edges, not levels: a cleared flag stays clear while its
  // condition lasts, instead of firing again on every cycle
  logic [5:0] lvl;
  logic [5:0] rise;
  assign lvl[0] = xmt_empty;
  assign lvl[1] = ~xmt_full;
  assign lvl[2] = ~rcv_empty;
  assign lvl[3] = rcv_full;
  assign lvl[4] = rcv_over;
  assign lvl[5] = xmt_over;

  ffi_edge #(
    .WIDTH (6)
  ) u_edge (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .level    (lvl),
    .rise     (rise)
  );

  // =====================================================
  // Fault detection
  // Faults are single-cycle pulses from the FIFOs and set their flag directly
  wire xmt_overrun   = xmt_bus_write & xmt_full;
  wire word_write    = xmt_bus_write & (xmt_bus_width == FFI_W_WORD);
  wire word_misalign = word_write & (xmt_byte_ptr != 2'b00);
  wire bus_wr_fault  = xmt_overrun | word_misalign;
  wire rcv_underrun  = rcv_bus_read & rcv_empty;
  wire rcv_bus_skew  = rcv_bus_read & rcv_bus_misalign;
  wire bus_rd_fault  = rcv_underrun | rcv_bus_skew;
  wire xmt_pop_fault = xmt_ext_pop & (xmt_empty | xmt_ext_misalign);

  // =====================================================
  // Set vector
  ffi_src_t set_v;
  assign set_v[`FFI_BIT_XMT_EMPTY]    = rise[0];
  assign set_v[`FFI_BIT_XMT_NOT_FULL] = rise[1];
  assign set_v[`FFI_BIT_RCV_NONEMPTY] = rise[2];
  assign set_v[`FFI_BIT_RCV_FULL]     = rise[3];
  assign set_v[`FFI_BIT_RCV_LEVEL]    = rise[4];
  assign set_v[`FFI_BIT_XMT_SPACE]    = rise[5];
  assign set_v[`FFI_BIT_BUS_WR_FAULT] = bus_wr_fault;
  assign set_v[`FFI_BIT_BUS_RD_FAULT] = bus_rd_fault;
  assign set_v[`FFI_BIT_RCV_PUSH]     = rcv_ext_push_fault;
  assign set_v[`FFI_BIT_XMT_POP]      = xmt_pop_fault;
  assign set_v[`FFI_BIT_EVT_HI:`FFI_BIT_EVT_LO] = flash_events;

  // =====================================================
  // Clear vector
  // Only bits written as one clear; a zero leaves its flag alone
  ffi_src_t clr_v;
  assign clr_v = wr_clear ? reg_wdata[14:0] : '0;

  // Per-bit next value; a set in the same cycle as its clear wins
  genvar gi;
  generate
    for (gi = 0; gi < $bits(ffi_src_t); gi++)
    begin : g_src
      assign raw_d[gi] = set_v[gi] | (raw_q[gi] & ~clr_v[gi]);
    end
  endgenerate

  // =====================================================
  // Register next values
  assign mask_d   = wr_mask   ? reg_wdata       : mask_q;
  assign thresh_d = wr_thresh ? reg_wdata[15:0] : thresh_q;

  // =====================================================
  // Raw source register
  always_ff @(posedge core_clk)
  begin
    if (sys_rst) raw_q <= `FFI_RAW_RST;
    else         raw_q <= raw_d;
  end

  // Mask register; every source masked until software opens it
  always_ff @(posedge core_clk)
  begin
    if (sys_rst) mask_q <= `FFI_MASK_RST;
    else         mask_q <= mask_d;
  end

  // Threshold register; zero means any entry crosses it
  always_ff @(posedge core_clk)
  begin
    if (sys_rst) thresh_q <= {`FFI_THRESH_RST, `FFI_THRESH_RST};
    else         thresh_q <= thresh_d;
  end

  // =====================================================
  // Read select
  // Clear register is write-only and reads zero, like any unmapped offset
  wire        sel_raw     = (reg_addr == `FFI_OFS_RAW);
  wire        sel_mask    = (reg_addr == `FFI_OFS_MASK);
  wire        sel_thresh  = (reg_addr == `FFI_OFS_THRESH);
  wire [31:0] raw_word    = {17'h00000, raw_q};
  wire [31:0] thresh_word = {16'h0000, thresh_q};
  wire [31:0] rmux        = sel_raw    ? raw_word    :
                            sel_mask   ? mask_q      :
                            sel_thresh ? thresh_word : 32'h00000000;

  // Read data captured once per read and held until the next one, so a
  // slow poller still sees the value it asked for
  assign rdata_d = rd_any ? rmux : rdata_q;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst) rdata_q <= `FFI_RDATA_RST;
    else         rdata_q <= rdata_d;
  end
  assign reg_rdata = rdata_q;

  // =====================================================
  // Interrupt output
  // Built from flops only, so bus decode cannot glitch the pin
  ffi_src_t pend;
  assign pend = raw_q & ~mask_q[14:0];
  assign irq  = |pend;
endmodule : ffi_irq_logic

// ===== inc/ffi_regs.svh
// Register offsets, field positions, reset values for the flash FIFO interrupt logic
`ifndef FFI_REGS_SVH
`define FFI_REGS_SVH

// =====================================================
// Offsets
`define FFI_OFS_RAW    8'h00
`define FFI_OFS_MASK   8'h04
`define FFI_OFS_CLEAR  8'h08
`define FFI_OFS_THRESH 8'h0C

// =====================================================
// Source bit positions
`define FFI_BIT_XMT_EMPTY    0
`define FFI_BIT_XMT_SPACE    1
`define FFI_BIT_XMT_NOT_FULL 2
`define FFI_BIT_RCV_NONEMPTY 3
`define FFI_BIT_RCV_LEVEL    4
`define FFI_BIT_RCV_FULL     5
`define FFI_BIT_BUS_WR_FAULT 6
`define FFI_BIT_BUS_RD_FAULT 7
`define FFI_BIT_RCV_PUSH     8
`define FFI_BIT_XMT_POP      9
`define FFI_BIT_EVT_LO       10
`define FFI_BIT_EVT_HI       14

// =====================================================
// Reset values
`define FFI_MASK_RST   32'h0FFFFFFF
`define FFI_RAW_RST    15'h0000
`define FFI_THRESH_RST 8'h00
`define FFI_RDATA_RST  32'h00000000

`endif

// ===== inc/ffi_pkg.sv
// Types shared by the flash FIFO interrupt logic
package ffi_pkg;
  typedef logic [14:0] ffi_src_t;
  typedef enum logic [1:0] {
    FFI_W_BYTE = 2'b00,
    FFI_W_HALF = 2'b01,
    FFI_W_WORD = 2'b10
  } ffi_width_t;
endpackage : ffi_pkg

// ===== hdl/ffi_edge.sv
// Per-bit rising edge detector for FIFO status levels
`timescale 1ns/1ps
module ffi_edge
  import ffi_pkg::*;
#(
  parameter int WIDTH = 6
)(
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);
  // Elaboration check; a zero-width detector has nothing to watch
  if (WIDTH < 1)
  begin : g_bad_width
    $error("ffi_edge: WIDTH must be positive");
  end

  logic [WIDTH-1:0] prev_q;

  // Previous level; reset to ones so a level high at reset release is no edge
  always_ff @(posedge core_clk)
  begin
    if (sys_rst) prev_q <= '1;
    else         prev_q <= level;
  end

  // Edge per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      assign rise[i] = level[i] & ~prev_q[i];
    end
  endgenerate
endmodule : ffi_edge

// ===== bench/ffi_irq_sva.sv
// Checker for the flash FIFO interrupt logic
`timescale 1ns/1ps
module ffi_irq_sva
  import ffi_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        reg_sel,
  input wire logic        reg_write,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic [4:0]  flash_events,
  input wire logic        irq
);
  // ===
  // Bus decode for the properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire rd = reg_sel & ~reg_write;
  wire wr = reg_sel & reg_write;
  sequence unm_s;
    wr && reg_addr == 8'h04 && reg_wdata == 32'h0;
  endsequence
  rst_quiet_a: assert property ($past(sys_rst) |-> !irq && reg_rdata == 32'h0)
    else $error("irq or rdata set after reset");
  clr_read_a: assert property (rd && reg_addr == 8'h08 |=> reg_rdata == 32'h0)
    else $error("clear register read not zero");
  raw_upper_a: assert property (rd && reg_addr == 8'h00 |=> reg_rdata[31:15] == 17'h0)
    else $error("raw upper bits set");
  rd_hold_a: assert property (!rd |=> $stable(reg_rdata))
    else $error("rdata moved without read");
  mask_all_a: assert property (wr && reg_addr == 8'h04 && reg_wdata == 32'hFFFFFFFF |=> !irq)
    else $error("irq with all masked");
  evt_irq_a: assert property (unm_s ##1 flash_events != 5'h0 |=> irq)
    else $error("unmasked event gave no irq");
  zero_clr_a: assert property (wr && reg_addr == 8'h08 && reg_wdata == 32'h0 && irq |=> irq)
    else $error("zero clear dropped irq");
  mask_rb_a: assert property (wr && reg_addr == 8'h04 ##1 rd && reg_addr == 8'h04 |=>
    reg_rdata == $past(reg_wdata, 2))
    else $error("mask readback wrong");
  cover property (unm_s);
  cover property (rd && reg_addr == 8'h00 ##1 reg_rdata != 32'h0);
  cover property ($rose(irq));
endmodule : ffi_irq_sva
bind ffi_irq_logic ffi_irq_sva u_sva (.*);

// ===== bench/ffi_cpu_model.sv
// Register bus master standing in for processor software
`timescale 1ns/1ps
module ffi_cpu_model (
  input  wire logic   core_clk,
  output logic        reg_sel,
  output logic        reg_write,
  output logic [7:0]  reg_addr,
  output logic [31:0] reg_wdata
);
  // ===
  // Idle bus at time zero
  initial {reg_sel, reg_write, reg_addr, reg_wdata} = '0;
  // One access; idle lines show inverted data so stale values never match
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_sel <= 1'b1;
    reg_write <= w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_sel <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : acc
  // Write then read back the same offset on the very next edge
  task wr_rd(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_sel <= 1'b1;
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 1'b0;
    @(posedge core_clk);
    reg_sel <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr_rd
endmodule : ffi_cpu_model

// ===== bench/ffi_irq_logic_tb.sv
// Self-checking bench for the flash FIFO interrupt logic
`timescale 1ns/1ps
module ffi_irq_logic_tb
  import ffi_pkg::*;
;
  logic core_clk = 0, sys_rst = 1, rdv = 0, irq, xmt_empty = 0, xmt_full = 1;
  logic xmt_bus_write = 0, xmt_ext_pop = 0, xmt_ext_misalign = 0, rcv_full = 0;
  logic rcv_empty = 1, rcv_bus_read = 0, rcv_bus_misalign = 0, rcv_ext_push_fault = 0;
  logic [7:0] xmt_space = 0, rcv_count = 0, reg_addr;
  logic [1:0] xmt_byte_ptr = 0;
  logic [4:0] flash_events = 0;
  logic [31:0] exp_q[$], reg_rdata, reg_wdata, r;
  logic reg_sel, reg_write;
  ffi_width_t xmt_bus_width = FFI_W_BYTE;
  int n_errors = 0, cmp_count = 0, seed = 32'h1C4D72A8;
  ffi_irq_logic dut (.*);
  ffi_cpu_model u_cpu (.*);
  initial forever #10 core_clk = ~core_clk;
  task wrap_up;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("Error %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_cpu.acc(1'b0, a, 32'h0);
  endtask : rd
  // ===
  // Read data lands one cycle after the read is taken
  always @(posedge core_clk)
  begin
    if (rdv) chk("rdata", reg_rdata, exp_q.pop_front());
    rdv <= reg_sel & ~reg_write;
  end
  // One source at a time: provoke, read, clear, read again
  task ev(input int b);
    @(posedge core_clk);
    case (b)
      0: xmt_empty <= 1'b1;
      1: xmt_space <= 8'($random(seed)) | 8'h01;
      2: xmt_full <= 1'b0;
      3: rcv_empty <= 1'b0;
      4: rcv_count <= 8'($random(seed)) | 8'h01;
      5: rcv_full <= 1'b1;
      6: begin xmt_bus_write <= 1; xmt_bus_width <= FFI_W_WORD; end
      7: {rcv_bus_read, rcv_bus_misalign} <= 2'b11;
      8: rcv_ext_push_fault <= 1'b1;
      9: xmt_ext_pop <= 1'b1;
      default: flash_events <= 5'h1 << (b - 10);
    endcase
    xmt_byte_ptr <= 2'($random(seed)) | 2'h1;
    @(posedge core_clk);
    {xmt_bus_write, rcv_bus_read, rcv_ext_push_fault, xmt_ext_pop, flash_events} <= '0;
    rd(8'h00, 32'h1 << b);
    chk("irq", irq, 1'b1);
    u_cpu.acc(1'b1, 8'h08, 32'h1 << b);
    rd(8'h00, 32'h0);
    $display("source %0d done", b);
  endtask : ev
  // Main sequence
  initial
  begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(8'h04, 32'h0FFFFFFF);
    rd(8'h08, 32'h0);
    r = $random(seed);
    u_cpu.acc(1'b1, 8'h04, r);
    rd(8'h04, r);
    r = $random(seed);
    exp_q.push_back(r);
    u_cpu.wr_rd(8'h04, r);
    u_cpu.acc(1'b1, 8'h04, 32'h0);
    $display("register test done");
    for (int b = 0; b < 15; b++) ev(b);
    // Overrun alone: byte write into a full transmit FIFO
    @(posedge core_clk);
    xmt_full <= 1'b1;
    xmt_bus_write <= 1'b1;
    xmt_bus_width <= FFI_W_BYTE;
    @(posedge core_clk) xmt_bus_write <= 1'b0;
    rd(8'h00, 32'h40);
    u_cpu.acc(1'b1, 8'h08, 32'h40);
    rd(8'h00, 32'h0);
    $display("overrun test done");
    u_cpu.acc(1'b1, 8'h04, 32'hFFFFFFFF);
    @(posedge core_clk) flash_events <= 5'h10;
    @(posedge core_clk) flash_events <= 5'h0;
    u_cpu.acc(1'b1, 8'h08, 32'h0);
    rd(8'h00, 32'h4000);
    chk("irq", irq, 1'b0);
    u_cpu.acc(1'b1, 8'h04, 32'h0);
    flash_events <= 5'h08;
    @(posedge core_clk) flash_events <= 5'h0;
    chk("irq", irq, 1'b1);
    u_cpu.acc(1'b1, 8'h08, 32'h0);
    rd(8'h00, 32'h6000);
    chk("irq", irq, 1'b1);
    $display("mask test done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(8'h04, 32'h0FFFFFFF);
    rd(8'h00, 32'h0);
    repeat (3) @(posedge core_clk);
    $display("reset test done");
    wrap_up();
  end
  // Watchdog well beyond the few hundred cycles needed
  initial
  begin
    #50us;
    n_errors++;
    wrap_up();
  end
endmodule : ffi_irq_logic_tb
